// file: ebc_boot_config.v
`timescale 1ns/100ps
`include "ebc_map.vh"
// Summary of operation
// R01 - Pin address is 10101 plus two pins
// R02 - Interface bit 4 picks address source
// R03 - Interface bit 7 picks speed variant
// R04 - Interface bit 3 enables boundary scan
// R05 - Interface bits 2..0 select host when bit 2 is clear; bit 2 set selects host pins
// R06 - Secure module address always stored byte
// R07 - Protocol set: 16 transmit, 8 receive bytes
// R08 - Defaults touch only writable bits
// R09 - Hardware version hardwired at fixed address
// R10 - Host reads only middle identifier byte
// R11 - Transmit CRC uses stored seed
// R12 - Protocol source address set by user
// R13 - Host ignores manufacturer data
// R14 - Stored version means init data revision
// R15 - Memory pages are sixty-four bytes
// R16 - Start-up copies reset area to registers
// R17 - Protocol load copies selected set
// R18 - Host interfaces wait for boot done
module ebc_boot_config #(
  parameter AW = 13,
  parameter [7:0] HW_VERSION = 8'hA5 // Arbitrary value
) (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  pready,
  prdata,
  pslverr,
  nv_rd_req,
  nv_rd_addr,
  nv_rd_valid,
  nv_rd_data,
  iface_select_pin_a,
  iface_select_pin_b,
  host_pins,
  boot_done,
  host_sel,
  host_enable,
  bus_addr,
  bus_speed_plus_select,
  scan_enable,
  secure_module_addr,
  transmit_crc_seed,
  receive_crc_seed,
  prot_wr_valid,
  prot_wr_is_tx,
  prot_wr_index,
  prot_wr_data
);
  input wire pclk;
  input wire presetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg pready;
  output reg [31:0] prdata;
  output reg pslverr;
  output wire nv_rd_req;
  output wire [AW-1:0] nv_rd_addr;
  input wire nv_rd_valid;
  input wire [7:0] nv_rd_data;
  input wire iface_select_pin_a;
  input wire iface_select_pin_b;
  input wire [2:0] host_pins;
  output reg boot_done;
  output reg [2:0] host_sel;
  output reg host_enable;
  output reg [6:0] bus_addr;
  output reg bus_speed_plus_select;
  output reg scan_enable;
  output reg [7:0] secure_module_addr;
  output reg [15:0] transmit_crc_seed;
  output reg [15:0] receive_crc_seed;
  output reg prot_wr_valid;
  output reg prot_wr_is_tx;
  output reg [4:0] prot_wr_index;
  output reg [7:0] prot_wr_data;

  // ---------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------
  localparam [3:0] ST_START = 4'h1;
  localparam [3:0] ST_BOOT = 4'h2;
  localparam [3:0] ST_IDLE = 4'h4;
  localparam [3:0] ST_PROT = 4'h8;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg rd_start;
  reg [AW-1:0] rd_addr;
  reg [6:0] rd_count;
  wire byte_valid;
  wire [6:0] byte_index;
  wire rd_busy;
  reg started_r;

  reg [7:0] bus_addr_byte_r;
  reg [7:0] iface_cfg_r;
  reg [7:0] secure_addr_r;
  reg [7:0] def_rx_prot_r;
  reg [7:0] def_tx_prot_r;
  reg [15:0] tx_crc_r;
  reg [15:0] rx_crc_r;
  reg [7:0] part_id_r;
  reg [7:0] nv_version_r;
  reg [7:0] load_set_r;
  reg [AW-1:0] prot_base_r;

  wire apb_wr;
  wire apb_rd;
  reg load_req;
  reg [AW-1:0] prot_src;
  reg [7:0] nv_byte_r;

  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && penable && !pwrite && pready;

  // Protocol set source: base plus set number times set size
  always @* begin
    prot_src = prot_base_r +
      ({{(AW-8){1'b0}}, load_set_r} * {{(AW-5){1'b0}},
      `EBC_PROT_SET_BYTES}); // R12
  end

  // One reader serves both the boot copy and protocol loads
  ebc_nv_reader #(
    .AW(AW)
  ) u_reader (
    .pclk(pclk),
    .presetn(presetn),
    .start(rd_start),
    .start_addr(rd_addr),
    .count(rd_count),
    .nv_rd_req(nv_rd_req),
    .nv_rd_addr(nv_rd_addr),
    .nv_rd_valid(nv_rd_valid),
    .byte_valid(byte_valid),
    .byte_index(byte_index),
    .busy(rd_busy)
  );

  // Memory data stands only in its valid cycle, so hold it here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_byte_r <= 8'h00;
    end else if (nv_rd_req && nv_rd_valid) begin
      nv_byte_r <= nv_rd_data;
    end
  end

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    rd_start = 1'b0;
    rd_addr = {AW{1'b0}};
    rd_count = 7'h00;
    case (state_r)
      ST_START: begin
        rd_start = 1'b1; // R16
        rd_count = `EBC_PAGE_BYTES; // R15
        state_nxt = ST_BOOT;
      end
      ST_BOOT: begin
        if (started_r && !rd_busy) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (load_req) begin
          rd_start = 1'b1; // R17
          rd_addr = prot_src;
          rd_count = {2'b00, `EBC_PROT_SET_BYTES}; // R07
          state_nxt = ST_PROT;
        end
      end
      ST_PROT: begin
        if (started_r && !rd_busy) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_START;
      end
    endcase
  end

  // Reader busy lags start by one edge; started_r covers that gap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_START;
      started_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      started_r <= rd_start ? 1'b0 : (rd_busy ? 1'b1 : started_r);
    end
  end

  // ---------------------------------------------------------------
  // Configuration store, filled at boot, then software owned except part ID and version
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_addr_byte_r <= 8'h00;
      iface_cfg_r <= `EBC_IF_RESET;
      secure_addr_r <= 8'h00;
      def_rx_prot_r <= 8'h00;
      def_tx_prot_r <= 8'h00;
      tx_crc_r <= 16'h0000;
      rx_crc_r <= 16'h0000;
      part_id_r <= 8'h00;
      nv_version_r <= 8'h00;
    end else if (state_r == ST_BOOT && byte_valid) begin
      case (byte_index[5:0])
        `EBC_NV_PART_ID_MID: part_id_r <= nv_byte_r; // R10
        `EBC_NV_VERSION: nv_version_r <= nv_byte_r; // R14
        `EBC_NV_BUS_ADDR: bus_addr_byte_r <= nv_byte_r;
        // Reserved bits 6..5 keep their value
        `EBC_NV_IFACE_CFG: iface_cfg_r <= (nv_byte_r & `EBC_IF_WR_MASK)
          | (iface_cfg_r & ~`EBC_IF_WR_MASK); // R08
        `EBC_NV_SECURE_ADDR: secure_addr_r <= nv_byte_r;
        `EBC_NV_DEF_RX_PROT: def_rx_prot_r <= nv_byte_r;
        `EBC_NV_DEF_TX_PROT: def_tx_prot_r <= nv_byte_r;
        `EBC_NV_TX_CRC_LO: tx_crc_r[7:0] <= nv_byte_r; // R11
        `EBC_NV_TX_CRC_HI: tx_crc_r[15:8] <= nv_byte_r; // R11
        `EBC_NV_RX_CRC_LO: rx_crc_r[7:0] <= nv_byte_r;
        `EBC_NV_RX_CRC_HI: rx_crc_r[15:8] <= nv_byte_r;
        default: begin
          // Trim and manufacturer bytes are not kept (R13)
        end
      endcase
    end else if (apb_wr) begin
      case (paddr)
        `EBC_REG_BUS_ADDR: bus_addr_byte_r <= pwdata[7:0];
        `EBC_REG_IFACE_CFG: iface_cfg_r <= (pwdata[7:0] & `EBC_IF_WR_MASK)
          | (iface_cfg_r & ~`EBC_IF_WR_MASK); // R08
        `EBC_REG_SECURE_ADDR: secure_addr_r <= pwdata[7:0];
        `EBC_REG_DEF_RX_PROT: def_rx_prot_r <= pwdata[7:0];
        `EBC_REG_DEF_TX_PROT: def_tx_prot_r <= pwdata[7:0];
        `EBC_REG_TX_CRC: tx_crc_r <= pwdata[15:0];
        `EBC_REG_RX_CRC: rx_crc_r <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Control: set number, source base, load strobe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_set_r <= 8'h00;
      prot_base_r <= `EBC_PROT_AREA_BASE;
      load_req <= 1'b0;
    end else begin
      if (state_r == ST_PROT) begin
        load_req <= 1'b0;
      end
      if (apb_wr && paddr == `EBC_REG_CONTROL && state_r == ST_IDLE) begin
        load_set_r <= pwdata[7:0];
        prot_base_r <= pwdata[16+AW-1:16]; // R12
        load_req <= pwdata[31];
      end
    end
  end

  // ---------------------------------------------------------------
  // Protocol set write-out: first 16 bytes transmit, then receive
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_wr_valid <= 1'b0;
      prot_wr_is_tx <= 1'b0;
      prot_wr_index <= 5'h00;
      prot_wr_data <= 8'h00;
    end else begin
      prot_wr_valid <= (state_r == ST_PROT) && byte_valid;
      if ((state_r == ST_PROT) && byte_valid) begin
        prot_wr_is_tx <= byte_index < {2'b00, `EBC_PROT_TX_BYTES}; // R07
        prot_wr_index <= (byte_index < {2'b00, `EBC_PROT_TX_BYTES}) ?
          byte_index[4:0] : byte_index[4:0] - `EBC_PROT_TX_BYTES; // R07
        prot_wr_data <= nv_byte_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Derived outputs, held at reset values until the boot copy ends
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_done <= 1'b0;
      host_sel <= 3'h0;
      host_enable <= 1'b0;
      bus_addr <= 7'h00;
      bus_speed_plus_select <= 1'b1;
      scan_enable <= 1'b1;
      secure_module_addr <= 8'h00;
      transmit_crc_seed <= 16'h0000;
      receive_crc_seed <= 16'h0000;
    end else if (state_r == ST_IDLE || state_r == ST_PROT) begin
      boot_done <= 1'b1;
      host_enable <= 1'b1; // R18
      host_sel <= iface_cfg_r[2] ? host_pins : iface_cfg_r[2:0]; // R05
      bus_addr <= iface_cfg_r[`EBC_IF_ADDR_SRC_BIT] ?
        bus_addr_byte_r[6:0] :
        {`EBC_PIN_ADDR_TOP, iface_select_pin_b,
        iface_select_pin_a}; // R01 R02
      bus_speed_plus_select <= iface_cfg_r[`EBC_IF_SPEED_BIT]; // R03
      scan_enable <= iface_cfg_r[`EBC_IF_SCAN_BIT]; // R04
      secure_module_addr <= secure_addr_r; // R06
      transmit_crc_seed <= tx_crc_r; // R11
      receive_crc_seed <= rx_crc_r;
    end
  end

  // ---------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped address
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        case (paddr)
          `EBC_REG_BUS_ADDR: prdata[7:0] <= bus_addr_byte_r;
          `EBC_REG_IFACE_CFG: prdata[7:0] <= iface_cfg_r;
          `EBC_REG_SECURE_ADDR: prdata[7:0] <= secure_addr_r;
          `EBC_REG_DEF_RX_PROT: prdata[7:0] <= def_rx_prot_r;
          `EBC_REG_DEF_TX_PROT: prdata[7:0] <= def_tx_prot_r;
          `EBC_REG_TX_CRC: prdata[15:0] <= tx_crc_r;
          `EBC_REG_RX_CRC: prdata[15:0] <= rx_crc_r;
          `EBC_REG_STATUS: prdata[3:0] <= state_r;
          `EBC_REG_CONTROL: prdata[7:0] <= load_set_r;
          `EBC_REG_PART_ID: prdata[7:0] <= part_id_r; // R10
          `EBC_REG_NV_VERSION: prdata[7:0] <= nv_version_r; // R14
          `EBC_REG_HW_VERSION: prdata[7:0] <= HW_VERSION; // R09
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // ebc_boot_config

// file: ebc_boot_config_properties.sv
`timescale 1ns/100ps
// Checks config outputs against a shadow of the stored config bytes
module ebc_boot_config_properties #(
  parameter AW = 13
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic [AW-1:0] nv_rd_addr,
  input logic nv_rd_valid,
  input logic [7:0] nv_rd_data,
  input logic iface_select_pin_a,
  input logic iface_select_pin_b,
  input logic [2:0] host_pins,
  input logic boot_done,
  input logic [2:0] host_sel,
  input logic host_enable,
  input logic [6:0] bus_addr,
  input logic bus_speed_plus_select,
  input logic scan_enable,
  input logic [7:0] secure_module_addr,
  input logic prot_wr_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] cfg_r, adr_r, sec_r;
  logic [6:0] nrd_r;
  logic wr, bt;
  assign wr = psel && penable && pready && pwrite;
  assign bt = nv_rd_valid && !boot_done;
  // Shadow copy; bits 6:5 of the interface byte never change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 8'h8C;
      adr_r <= 8'h00;
      sec_r <= 8'h00;
      nrd_r <= 7'h00;
    end else begin
      if (bt) nrd_r <= nrd_r + 7'h01;
      if (bt && nv_rd_addr == 'h21)
        cfg_r <= (nv_rd_data & 8'h9F) | (cfg_r & 8'h60);
      if (wr && paddr == 12'h024)
        cfg_r <= (pwdata[7:0] & 8'h9F) | (cfg_r & 8'h60);
      if (bt && nv_rd_addr == 'h20) adr_r <= nv_rd_data;
      if (wr && paddr == 12'h020) adr_r <= pwdata[7:0];
      if (bt && nv_rd_addr == 'h22) sec_r <= nv_rd_data;
      if (wr && paddr == 12'h028) sec_r <= pwdata[7:0];
    end
  end
  sequence s_live;
    boot_done && $past(boot_done);
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (psel && !penable |=> s_answer)
    else $error("ready not a single cycle after setup");
  a_pin_addr: assert property (s_live ##0 !cfg_r[4] |=>
    bus_addr == {5'h15, $past(iface_select_pin_b), $past(iface_select_pin_a)})
    else $error("pin sourced bus address wrong");
  a_stored_addr: assert property (s_live ##0 cfg_r[4] |=>
    bus_addr == $past(adr_r[6:0]))
    else $error("stored bus address wrong");
  a_speed_scan: assert property (s_live |=>
    bus_speed_plus_select == $past(cfg_r[7]) && scan_enable == $past(cfg_r[3]))
    else $error("speed or scan enable wrong");
  a_host_decode: assert property (s_live |=> host_sel ==
    ($past(cfg_r[2]) ? $past(host_pins) : $past(cfg_r[2:0])))
    else $error("host select wrong");
  a_secure_addr: assert property (s_live |=>
    secure_module_addr == $past(sec_r))
    else $error("secure module address wrong");
  a_boot_gate: assert property (host_enable |-> boot_done)
    else $error("host enabled before boot done");
  a_boot_len: assert property ($rose(boot_done) |-> nrd_r == 7'h40)
    else $error("boot read count wrong");
  a_prot_pulse: assert property (prot_wr_valid |=> !prot_wr_valid)
    else $error("protocol strobe longer than one cycle");
endmodule // ebc_boot_config_properties

// file: ebc_map.vh
`ifndef EBC_MAP_VH
`define EBC_MAP_VH
// ---------------------------------------------------------------
// Non-volatile page 0 byte addresses
// ---------------------------------------------------------------
`define EBC_NV_PART_ID_MID 6'h01
`define EBC_NV_VERSION 6'h03
`define EBC_NV_BUS_ADDR 6'h20
`define EBC_NV_IFACE_CFG 6'h21
`define EBC_NV_SECURE_ADDR 6'h22
`define EBC_NV_DEF_RX_PROT 6'h23
`define EBC_NV_DEF_TX_PROT 6'h24
`define EBC_NV_TX_CRC_LO 6'h26
`define EBC_NV_TX_CRC_HI 6'h27
`define EBC_NV_RX_CRC_LO 6'h28
`define EBC_NV_RX_CRC_HI 6'h29
`define EBC_NV_LAST 6'h29
`define EBC_PAGE_BYTES 7'h40
// ---------------------------------------------------------------
// Protocol set layout
// ---------------------------------------------------------------
`define EBC_PROT_TX_BYTES 5'h10
`define EBC_PROT_RX_BYTES 5'h08
`define EBC_PROT_SET_BYTES 5'h18
`define EBC_PROT_AREA_BASE 13'h1C00
// ---------------------------------------------------------------
// APB register byte offsets
// ---------------------------------------------------------------
`define EBC_REG_BUS_ADDR 12'h020
`define EBC_REG_IFACE_CFG 12'h024
`define EBC_REG_SECURE_ADDR 12'h028
`define EBC_REG_DEF_RX_PROT 12'h02C
`define EBC_REG_DEF_TX_PROT 12'h030
`define EBC_REG_TX_CRC 12'h034
`define EBC_REG_RX_CRC 12'h038
`define EBC_REG_STATUS 12'h040
`define EBC_REG_CONTROL 12'h044
`define EBC_REG_PART_ID 12'h048
`define EBC_REG_NV_VERSION 12'h04C
`define EBC_REG_HW_VERSION 12'h1FC
// ---------------------------------------------------------------
// Interface byte fields and writable mask
// ---------------------------------------------------------------
`define EBC_IF_SPEED_BIT 7
`define EBC_IF_ADDR_SRC_BIT 4
`define EBC_IF_SCAN_BIT 3
`define EBC_IF_WR_MASK 8'h9F
`define EBC_IF_RESET 8'h8C
`define EBC_PIN_ADDR_TOP 5'h15
`define EBC_HOST_UART 3'h0
`define EBC_HOST_SERIAL 3'h1
`define EBC_HOST_SPI 3'h2
`define EBC_HOST_LV_SERIAL 3'h3
`endif

// file: ebc_nv_model.sv
`timescale 1ns/100ps
// Memory array model: answers each read after lag idle cycles
module ebc_nv_model (
  input logic pclk,
  input logic presetn,
  input logic [2:0] lag,
  input logic nv_rd_req,
  input logic [12:0] nv_rd_addr,
  output logic nv_rd_valid,
  output logic [7:0] nv_rd_data
);
  logic [7:0] mem [0:8191];
  logic [2:0] wait_r;
  // Data toggles outside the answer cycle so a stale byte never passes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_rd_valid <= 1'b0;
      nv_rd_data <= 8'h5A;
      wait_r <= 3'h0;
    end else if (nv_rd_req && !nv_rd_valid && wait_r >= lag) begin
      nv_rd_valid <= 1'b1;
      nv_rd_data <= mem[nv_rd_addr];
      wait_r <= 3'h0;
    end else begin
      nv_rd_valid <= 1'b0;
      nv_rd_data <= ~nv_rd_data;
      if (nv_rd_req && !nv_rd_valid) wait_r <= wait_r + 3'h1;
    end
  end
endmodule // ebc_nv_model

// file: ebc_nv_reader.v
`timescale 1ns/100ps
// Sequential byte reader towards the memory array: one request at a time
module ebc_nv_reader #(
  parameter AW = 13
) (
  pclk,
  presetn,
  start,
  start_addr,
  count,
  nv_rd_req,
  nv_rd_addr,
  nv_rd_valid,
  byte_valid,
  byte_index,
  busy
);
  input wire pclk;
  input wire presetn;
  input wire start;
  input wire [AW-1:0] start_addr;
  input wire [6:0] count;
  output reg nv_rd_req;
  output reg [AW-1:0] nv_rd_addr;
  input wire nv_rd_valid;
  output reg byte_valid;
  output reg [6:0] byte_index;
  output reg busy;

  reg [6:0] left_r;

  // Issue a request, wait for valid, step to the next byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_rd_req <= 1'b0;
      nv_rd_addr <= {AW{1'b0}};
      byte_valid <= 1'b0;
      byte_index <= 7'h00;
      busy <= 1'b0;
      left_r <= 7'h00;
    end else begin
      byte_valid <= 1'b0;
      if (!busy) begin
        if (start && count != 7'h00) begin
          busy <= 1'b1;
          nv_rd_req <= 1'b1;
          nv_rd_addr <= start_addr;
          byte_index <= 7'h00;
          left_r <= count;
        end
      end else if (nv_rd_req && nv_rd_valid) begin
        byte_valid <= 1'b1;
        nv_rd_req <= 1'b0;
      end else if (byte_valid) begin
        if (left_r == 7'h01) begin
          busy <= 1'b0;
        end else begin
          left_r <= left_r - 7'h01;
          byte_index <= byte_index + 7'h01;
          nv_rd_addr <= nv_rd_addr + {{(AW-1){1'b0}}, 1'b1};
          nv_rd_req <= 1'b1;
        end
      end
    end
  end
endmodule // ebc_nv_reader

// file: tb_eeprom_boot_config.sv
`timescale 1ns/100ps
`include "ebc_map.vh"
module tb_eeprom_boot_config;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, nv_rd_req, nv_rd_valid, boot_done, host_enable, err;
  logic [12:0] nv_rd_addr, b;
  logic [7:0] nv_rd_data, secure_module_addr, prot_wr_data, w, adr, s;
  logic iface_select_pin_a = 1'b0, iface_select_pin_b = 1'b0;
  logic [2:0] host_pins = 3'h0, host_sel, lag = 3'h0;
  logic [6:0] bus_addr;
  logic bus_speed_plus_select, scan_enable, prot_wr_valid, prot_wr_is_tx;
  logic [15:0] transmit_crc_seed, receive_crc_seed;
  logic [4:0] prot_wr_index;
  int fails = 0, check_count = 0, n;
  localparam logic [7:0] HWV = 8'h3C; // Arbitrary version value
  ebc_boot_config #(.HW_VERSION(HWV)) dut (.*);
  ebc_nv_model mdl (.*);
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; ready, data and error are taken at the rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
    if (pready !== 1'b1) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic logic [31:0] m(input int a);
    return {24'h0, mdl.mem[a]};
  endfunction
  task automatic finish_test;
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hD2E4));
    // Manufacturer bytes are random too: nothing may depend on them
    for (int i = 0; i < 8192; i++) mdl.mem[i] = 8'($urandom);
    lag = 3'($urandom);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    do @(negedge pclk); while (boot_done !== 1'b1 && ++n < 3000);
    chk(host_enable, 1'b1);
    rchk(`EBC_REG_STATUS, 32'h4);
    rchk(`EBC_REG_BUS_ADDR, m(8'h20));
    rchk(`EBC_REG_IFACE_CFG, m(8'h21) & 32'h9F);
    rchk(`EBC_REG_SECURE_ADDR, m(8'h22));
    rchk(`EBC_REG_DEF_RX_PROT, m(8'h23));
    rchk(`EBC_REG_DEF_TX_PROT, m(8'h24));
    rchk(`EBC_REG_TX_CRC, (m(8'h27) << 8) | m(8'h26));
    rchk(`EBC_REG_RX_CRC, (m(8'h29) << 8) | m(8'h28));
    rchk(`EBC_REG_PART_ID, m(8'h01));
    rchk(`EBC_REG_NV_VERSION, m(8'h03));
    rchk(`EBC_REG_HW_VERSION, HWV);
    chk(transmit_crc_seed, (m(8'h27) << 8) | m(8'h26));
    chk(receive_crc_seed, (m(8'h29) << 8) | m(8'h28));
    apb(1'b0, 12'h100, 32'h0);
    chk(err, 1'b1);
    adr = 8'($urandom);
    apb(1'b1, `EBC_REG_BUS_ADDR, {24'h0, adr});
    // Every host code with both address sources and random pins
    for (int i = 0; i < 16; i++) begin
      w = 8'($urandom);
      w[2:0] = i[2:0];
      w[4] = i[3];
      @(posedge pclk);
      {iface_select_pin_b, iface_select_pin_a, host_pins} <= 5'($urandom);
      apb(1'b1, `EBC_REG_IFACE_CFG, {24'h0, w});
      repeat (2) @(negedge pclk);
      chk(host_sel, w[2] ? host_pins : w[2:0]);
      chk(bus_addr, w[4] ? adr[6:0] :
        {5'h15, iface_select_pin_b, iface_select_pin_a});
      chk(bus_speed_plus_select, w[7]);
      chk(scan_enable, w[3]);
      chk(secure_module_addr, m(8'h22));
    end
    rchk(`EBC_REG_IFACE_CFG, w & 8'h9F);
    // Default area with a random set, then a user base with a slow memory
    for (int k = 0; k < 2; k++) begin
      s = k ? 8'h01 : 8'($urandom % 4);
      b = k ? 13'h0100 : `EBC_PROT_AREA_BASE;
      @(posedge pclk);
      lag <= k ? 3'h5 : 3'h0;
      apb(1'b1, `EBC_REG_CONTROL, {3'b100, b, 8'h00, s});
      for (int j = 0; j < 24; j++) begin
        n = 0;
        do @(negedge pclk); while (prot_wr_valid !== 1'b1 && ++n < 100);
        chk({prot_wr_is_tx, prot_wr_index},
          j < 16 ? 32'h20 + j : j - 16);
        chk(prot_wr_data, m(b + s * 24 + j));
      end
    end
    repeat (4) @(posedge pclk);
    rchk(`EBC_REG_STATUS, 32'h4);
    finish_test();
  end
endmodule // tb_eeprom_boot_config
bind ebc_boot_config ebc_boot_config_properties #(.AW(AW)) u_props (.*);
